// >>> hdl/pmc_pkg.sv
package pmc_pkg;

    // ****************************************************************
    // Register indices and bus geometry
    // ****************************************************************
    localparam int         APB_AW        = 12;
    localparam logic [7:0] IDX_PORT1_CTL = 8'h1D;
    localparam logic [7:0] IDX_PORT2_CTL = 8'h2D;
    localparam logic [7:0] IDX_GLB_PWR   = 8'hC3;
    localparam logic [7:0] IDX_GO_SLEEP  = 8'hC4;
    localparam logic [7:0] IDX_PWR_STAT  = 8'hC5;

    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int         GLB_MODE_LSB   = 0;
    localparam int         GLB_PLL_OFF    = 2;
    localparam int         PORT_PDN_BIT   = 3;
    localparam int         STAT_ED_LOW    = 0;
    localparam int         STAT_PS_ACT    = 1;
    localparam int         STAT_PLL_EN    = 2;
    localparam int         STAT_MAC_EN    = 3;
    localparam int         STAT_HOST_EN   = 4;
    localparam logic [7:0] RST_PORT_CTL   = 8'h00;
    localparam logic [7:0] RST_GLB_PWR    = 8'h00;
    localparam logic [7:0] RST_GO_SLEEP   = 8'h0A;

    // ****************************************************************
    // Power mode codes
    // ****************************************************************
    typedef enum logic [1:0] {
        PMC_NORMAL = 2'h0,
        PMC_ENERGY = 2'h1,
        PMC_SOFTPD = 2'h2,
        PMC_SAVING = 2'h3
    } pmc_mode_t;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS   = 10;
    localparam int PULSE_WIDTH_NS  = 120;
    localparam int PULSE_WIDTH_CYC =
        (PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam longint PULSE_PERIOD_NS = 64'd1000000000;
    localparam int PULSE_PERIOD_CYC = int'(PULSE_PERIOD_NS / CLK_PERIOD_NS);
    localparam int GS_UNIT_NS      = 1000000;
    localparam int GS_TICK_CYC     = GS_UNIT_NS / CLK_PERIOD_NS;

endpackage : pmc_pkg

// >>> hdl/pmc_link_pulse.sv
`timescale 1ns/1ps
module pmc_link_pulse
    import pmc_pkg::*;
#(
    parameter int PERIOD_CYC = PULSE_PERIOD_CYC,
    parameter int WIDTH_CYC  = PULSE_WIDTH_CYC
) (
    input  wire logic mclk,  // System clock.
    input  wire logic rst,   // Asynchronous reset, active high.
    input  wire logic en,    // Pulse train enable.
    output logic      pulse  // Line pulse, high for the pulse width.
);

    logic [31:0] cnt_r;
    logic [31:0] cnt_nxt;
    logic        pulse_nxt;
    wire         wrap = (cnt_r == 32'(PERIOD_CYC - 1));

    assign cnt_nxt   = (!en || wrap) ? 32'h00000000 : cnt_r + 32'h00000001;
    assign pulse_nxt = en && (cnt_r < 32'(WIDTH_CYC));

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_r <= 32'h00000000;
            pulse <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            pulse <= pulse_nxt;
        end
    end

    property p_pulse_width;
        @(posedge mclk) disable iff (rst)
        $rose(pulse) |-> ##11 (pulse || !en) ##1 !pulse;
    endproperty
    a_pulse_width: assert property (p_pulse_width)
        else $error("Line pulse width is not twelve cycles.");

    property p_pulse_gated;
        @(posedge mclk) disable iff (rst)
        pulse |-> $past(en);
    endproperty
    a_pulse_gated: assert property (p_pulse_gated)
        else $error("Line pulse seen without enable.");

endmodule : pmc_link_pulse

// >>> hdl/pmc_power_ctrl.sv
`timescale 1ns/1ps
module pmc_power_ctrl
    import pmc_pkg::*;
#(
    parameter int NPORT        = 2,
    parameter int GS_TICK      = GS_TICK_CYC,
    parameter int PULSE_PERIOD = PULSE_PERIOD_CYC
) (
    input  wire logic              mclk,          // System clock.
    input  wire logic              rst,           // Async reset, high.
    input  wire logic              psel,          // APB select.
    input  wire logic              penable,       // APB enable.
    input  wire logic              pwrite,        // APB write.
    input  wire logic [APB_AW-1:0] paddr,         // APB byte address.
    input  wire logic [31:0]       pwdata,        // APB write data.
    output logic [31:0]            prdata,        // APB read data.
    output logic                   pready,        // APB ready.
    output logic                   pslverr,       // APB error.
    input  wire logic              an_enable,     // Autoneg enabled.
    input  wire logic              cable_present, // Cable linked.
    input  wire logic              line_energy,   // Energy on cable.
    output logic                   pll_clk_en,    // PLL clocks run.
    output logic                   mac_en,        // MAC powered.
    output logic                   host_if_en,    // Host interface on.
    output logic [NPORT-1:0]       phy_tx_en,     // PHY transmitters.
    output logic [NPORT-1:0]       phy_rx_en,     // PHY full receivers.
    output logic [NPORT-1:0]       phy_pdn,       // Port PHY powered down.
    output logic                   energy_det_en, // Energy detector only.
    output logic                   line_pulse     // Link pulse to line.
);

    // ****************************************************************
    // Register file
    // ****************************************************************
    function automatic logic hit(input logic [APB_AW-1:0] a,
                                 input logic [7:0]        idx);
        hit = (a == {2'b00, idx, 2'b00});
    endfunction : hit

    typedef enum {ED_AWAKE, ED_ASLEEP} pmc_ed_t;

    logic [7:0]       port_ctl_r [NPORT];
    logic [7:0]       glb_pwr_r;
    logic [7:0]       go_sleep_r;
    logic [NPORT-1:0] pdn;
    pmc_mode_t        mode;
    pmc_ed_t          ed_r;
    pmc_ed_t          ed_nxt;
    logic             ps_act_r;
    logic [31:0]      tick_cnt_r;
    logic [8:0]       quiet_r;
    logic [8:0]       quiet_nxt;

    wire setup   = psel && !penable;
    wire wr_take = psel && penable && pready && pwrite;
    wire sel_p1  = hit(paddr, IDX_PORT1_CTL);
    wire sel_p2  = hit(paddr, IDX_PORT2_CTL);
    wire sel_glb = hit(paddr, IDX_GLB_PWR);
    wire sel_gs  = hit(paddr, IDX_GO_SLEEP);
    wire sel_st  = hit(paddr, IDX_PWR_STAT);
    wire mapped  = sel_p1 || sel_p2 || sel_glb || sel_gs || sel_st;
    wire bad_wr  = pwrite && sel_st;

    wire [7:0] stat_val = {3'h0, host_if_en, mac_en, pll_clk_en,
                           ps_act_r, (ed_r == ED_ASLEEP)};
    wire [7:0] rd_val =
        sel_p1  ? port_ctl_r[0] :
        sel_p2  ? port_ctl_r[NPORT-1] :
        sel_glb ? glb_pwr_r :
        sel_gs  ? go_sleep_r :
        sel_st  ? stat_val : 8'h00;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= setup;
            pslverr <= setup && (!mapped || bad_wr);
            prdata  <= (setup && !pwrite) ? {24'h000000, rd_val} : prdata;
        end
    end

    // Hardware never writes these; they hold through every power mode.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            glb_pwr_r  <= RST_GLB_PWR;
            go_sleep_r <= RST_GO_SLEEP;
        end else begin
            if (wr_take && sel_glb) begin
                glb_pwr_r <= pwdata[7:0];
            end
            if (wr_take && sel_gs) begin
                go_sleep_r <= pwdata[7:0];
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < NPORT; g++) begin : g_port
            wire sel_me = (g == 0) ? sel_p1 : sel_p2;
            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    port_ctl_r[g] <= RST_PORT_CTL;
                end else if (wr_take && sel_me) begin
                    port_ctl_r[g] <= pwdata[7:0];
                end
            end
            assign pdn[g] = port_ctl_r[g][PORT_PDN_BIT];
        end
    endgenerate

    assign mode = pmc_mode_t'(glb_pwr_r[GLB_MODE_LSB +: 2]);

    // ****************************************************************
    // Energy detect sleep timer
    // ****************************************************************
    wire in_ed   = (mode == PMC_ENERGY);
    wire gs_tick = (tick_cnt_r == 32'(GS_TICK - 1));
    wire over    = (quiet_r > {1'b0, go_sleep_r});

    always_comb begin
        quiet_nxt = quiet_r;
        if (!in_ed || line_energy) begin
            quiet_nxt = 9'h000;
        end else if (gs_tick && !quiet_r[8]) begin
            quiet_nxt = quiet_r + 9'h001;
        end
    end

    always_comb begin
        ed_nxt = ed_r;
        case (ed_r)
            ED_AWAKE: begin
                if (in_ed && over && !line_energy) begin
                    ed_nxt = ED_ASLEEP;
                end
            end
            ED_ASLEEP: begin
                if (!in_ed || line_energy) begin
                    ed_nxt = ED_AWAKE;
                end
            end
            default: ed_nxt = ED_AWAKE;
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tick_cnt_r <= 32'h00000000;
            quiet_r    <= 9'h000;
            ed_r       <= ED_AWAKE;
        end else begin
            tick_cnt_r <= (gs_tick || !in_ed) ? 32'h00000000
                                              : tick_cnt_r + 32'h00000001;
            quiet_r    <= quiet_nxt;
            ed_r       <= ed_nxt;
        end
    end

    // ****************************************************************
    // Block enables per mode
    // ****************************************************************
    wire asleep  = (ed_r == ED_ASLEEP);
    wire ps_cond = (mode == PMC_SAVING) && an_enable && !cable_present
                   && !line_energy;
    wire pll_off = glb_pwr_r[GLB_PLL_OFF];

    logic             pll_nxt;
    logic             core_nxt;
    logic [NPORT-1:0] tx_nxt;
    logic [NPORT-1:0] rx_nxt;
    logic             edet_nxt;

    always_comb begin
        pll_nxt  = 1'b1;
        core_nxt = 1'b1;
        tx_nxt   = ~pdn;
        rx_nxt   = ~pdn;
        edet_nxt = 1'b0;
        case (mode)
            PMC_NORMAL: begin
                pll_nxt = 1'b1;
            end
            PMC_ENERGY: begin
                pll_nxt = !asleep && !pll_off;
                if (asleep) begin
                    core_nxt = 1'b0;
                    tx_nxt   = '0;
                    rx_nxt   = '0;
                    edet_nxt = 1'b1;
                end
            end
            PMC_SOFTPD: begin
                pll_nxt  = 1'b0;
                core_nxt = 1'b0;
                tx_nxt   = '0;
                rx_nxt   = '0;
            end
            PMC_SAVING: begin
                rx_nxt = ps_cond ? '0 : ~pdn;
            end
            default: pll_nxt = 1'b1;
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pll_clk_en    <= 1'b1;
            mac_en        <= 1'b1;
            host_if_en    <= 1'b1;
            phy_tx_en     <= '1;
            phy_rx_en     <= '1;
            phy_pdn       <= '0;
            energy_det_en <= 1'b0;
            ps_act_r      <= 1'b0;
        end else begin
            pll_clk_en    <= pll_nxt;
            mac_en        <= core_nxt;
            host_if_en    <= core_nxt;
            phy_tx_en     <= tx_nxt;
            phy_rx_en     <= rx_nxt;
            phy_pdn       <= pdn;
            energy_det_en <= edet_nxt;
            ps_act_r      <= ps_cond;
        end
    end

    pmc_link_pulse #(
        .PERIOD_CYC (PULSE_PERIOD),
        .WIDTH_CYC  (PULSE_WIDTH_CYC)
    ) u_pulse (
        .mclk  (mclk),
        .rst   (rst),
        .en    (asleep && in_ed),
        .pulse (line_pulse)
    );

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_reset_mode;
        @(posedge mclk) $fell(rst) |-> mode == PMC_NORMAL;
    endproperty
    a_reset_mode: assert property (p_reset_mode)
        else $error("Mode is not normal after reset.");

    property p_softpd;
        @(posedge mclk) disable iff (rst)
        $past(mode) == PMC_SOFTPD |->
            !pll_clk_en && !mac_en && !host_if_en && phy_tx_en == '0;
    endproperty
    a_softpd: assert property (p_softpd)
        else $error("Soft power down left a block on.");

    property p_normal;
        @(posedge mclk) disable iff (rst)
        $past(mode) == PMC_NORMAL |->
            pll_clk_en && mac_en && host_if_en && phy_rx_en == ~$past(pdn);
    endproperty
    a_normal: assert property (p_normal)
        else $error("Normal mode has a block off.");

    property p_saving;
        @(posedge mclk) disable iff (rst)
        $past(mode) == PMC_SAVING |->
            pll_clk_en && mac_en && phy_tx_en == ~$past(pdn);
    endproperty
    a_saving: assert property (p_saving)
        else $error("Power saving turned off transmitter or core.");

    property p_wake_ps;
        @(posedge mclk) disable iff (rst)
        $past(line_energy) || $past(cable_present) |-> !ps_act_r;
    endproperty
    a_wake_ps: assert property (p_wake_ps)
        else $error("Power saving stayed active with line activity.");

    property p_port_pdn;
        @(posedge mclk) disable iff (rst)
        $past(pdn[0]) |-> phy_pdn[0] && !phy_tx_en[0] && !phy_rx_en[0];
    endproperty
    a_port_pdn: assert property (p_port_pdn)
        else $error("Port one powered although its bit is set.");

    property p_sleep_entry;
        @(posedge mclk) disable iff (rst)
        $rose(asleep) |-> $past(quiet_r) > {1'b0, $past(go_sleep_r)};
    endproperty
    a_sleep_entry: assert property (p_sleep_entry)
        else $error("Low-power state entered before go-sleep time.");

    property p_timer_restart;
        @(posedge mclk) disable iff (rst)
        line_energy |=> quiet_r == 9'h000;
    endproperty
    a_timer_restart: assert property (p_timer_restart)
        else $error("Go-sleep timer not restarted by energy.");

    sequence s_energy_asleep;
        asleep && in_ed && line_energy;
    endsequence
    property p_wake_ed;
        @(posedge mclk) disable iff (rst)
        s_energy_asleep |=> !asleep ##1 pll_clk_en == !pll_off;
    endproperty
    a_wake_ed: assert property (p_wake_ed)
        else $error("Energy did not wake the low-power state.");

    property p_low_power;
        @(posedge mclk) disable iff (rst)
        $past(asleep) && $past(in_ed) |->
            energy_det_en && !mac_en && !pll_clk_en && phy_rx_en == '0;
    endproperty
    a_low_power: assert property (p_low_power)
        else $error("Low-power state left circuitry running.");

    property p_exit_softpd;
        @(posedge mclk) disable iff (rst)
        wr_take && sel_glb && pwdata[1:0] == 2'h0 |=> ##1 pll_clk_en && mac_en;
    endproperty
    a_exit_softpd: assert property (p_exit_softpd)
        else $error("Writing normal code did not resume operation.");

endmodule : pmc_power_ctrl

// >>> bench/pmc_power_ctrl_test.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin \
    num_errors++; $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp); \
    end end
module pmc_power_ctrl_test
    import pmc_pkg::*;
;
    localparam int TICK = 4;
    localparam int PER  = 40;

    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        an_enable = 1'b1;
    logic        cable_present = 1'b0;
    logic        line_energy = 1'b0;
    logic        pll_clk_en;
    logic        mac_en;
    logic        host_if_en;
    logic [1:0]  phy_tx_en;
    logic [1:0]  phy_rx_en;
    logic [1:0]  phy_pdn;
    logic        energy_det_en;
    logic        line_pulse;
    logic [7:0]  ctl;
    logic [31:0] q;
    logic        e;
    logic [31:0] r;
    logic [31:0] seed = 32'h51E458D3;
    int          num_errors = 0;
    int          n_tests = 0;

    assign ctl = {pll_clk_en, mac_en, host_if_en, phy_tx_en, phy_rx_en,
                  energy_det_en};

    always #5 mclk = ~mclk;

    pmc_power_ctrl #(.NPORT(2), .GS_TICK(TICK), .PULSE_PERIOD(PER))
    u_pmc_power_ctrl (
        .mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .an_enable(an_enable),
        .cable_present(cable_present), .line_energy(line_energy),
        .pll_clk_en(pll_clk_en), .mac_en(mac_en), .host_if_en(host_if_en),
        .phy_tx_en(phy_tx_en), .phy_rx_en(phy_rx_en), .phy_pdn(phy_pdn),
        .energy_det_en(energy_det_en), .line_pulse(line_pulse)
    );

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    // Packed as pll, mac, host, tx[1:0], rx[1:0], energy detector.
    function automatic logic [7:0] exp_ctl(input logic [1:0] m,
        input logic pll_off, input logic asleep, input logic sav);
        case (m)
            PMC_NORMAL: exp_ctl = 8'hFE;
            PMC_ENERGY: exp_ctl = asleep ? 8'h01 : {~pll_off, 7'h7E};
            PMC_SOFTPD: exp_ctl = 8'h00;
            default:    exp_ctl = {5'h1F, ~sav, ~sav, 1'b0};
        endcase
    endfunction : exp_ctl

    task automatic apb(input logic w, input logic [7:0] i,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {2'b00, i, 2'b00};
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge mclk);
        end
        if (n == 20) num_errors++;
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : settle

    task automatic wait_edet(input logic v, input int lim);
        int i;
        for (i = 0; i < lim && energy_det_en !== v; i++) @(posedge mclk);
        `CHK(energy_det_en, v)
    endtask : wait_edet

    task automatic pulse_check();
        int i;
        int w;
        int p;
        w = 0;
        // Skip a pulse already under way so the width is measured whole.
        for (i = 0; i < 60 && line_pulse === 1'b1; i++) @(posedge mclk);
        for (i = 0; i < 60 && line_pulse !== 1'b1; i++) @(posedge mclk);
        while (line_pulse === 1'b1 && w < 50) begin
            w++;
            @(posedge mclk);
        end
        p = w;
        while (line_pulse !== 1'b1 && p < 100) begin
            p++;
            @(posedge mclk);
        end
        `CHK(w, PULSE_WIDTH_CYC)
        `CHK(p, PER)
    endtask : pulse_check

    task automatic give_verdict();
        $display("errors %0d of %0d checks", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : give_verdict

    initial begin
        #(5000 * 10);
        num_errors++;
        give_verdict();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        #1;
        `CHK({ctl, phy_pdn, line_pulse}, 11'h7F0)
        apb(1'b0, IDX_GLB_PWR, 32'h0);
        `CHK(q, 32'h0)
        apb(1'b0, IDX_GO_SLEEP, 32'h0);
        `CHK(q, {24'h0, RST_GO_SLEEP})
        apb(1'b0, IDX_PORT2_CTL, 32'h0);
        `CHK(q, {24'h0, RST_PORT_CTL})
        apb(1'b0, IDX_PWR_STAT, 32'h0);
        `CHK(q, 32'h1C)
        apb(1'b0, 8'h00, 32'h0);
        `CHK(e, 1'b1)
        apb(1'b1, IDX_PWR_STAT, 32'hFF);
        `CHK(e, 1'b1)
        repeat (8) begin
            r = xs();
            apb(1'b1, IDX_GO_SLEEP, r);
            `CHK(e, 1'b0)
            apb(1'b0, IDX_GO_SLEEP, 32'h0);
            `CHK(q, {24'h0, r[7:0]})
            apb(1'b1, IDX_PORT1_CTL, r);
            apb(1'b1, IDX_PORT2_CTL, ~r);
            apb(1'b0, IDX_PORT1_CTL, 32'h0);
            `CHK(q, {24'h0, r[7:0]})
            settle(2);
            `CHK(phy_pdn, {~r[3], r[3]})
        end
        apb(1'b1, IDX_PORT1_CTL, 32'h0);
        apb(1'b1, IDX_PORT2_CTL, 32'h0);
        apb(1'b1, IDX_GO_SLEEP, 32'h3);
        line_energy <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            for (int b = 0; b < 2; b++) begin
                apb(1'b1, IDX_GLB_PWR, {29'h0, 1'(b), 2'(m)});
                settle(3);
                `CHK(ctl, exp_ctl(2'(m), 1'(b), 1'b0, 1'b0))
                apb(1'b0, IDX_GLB_PWR, 32'h0);
                `CHK(q, {29'h0, 1'(b), 2'(m)})
            end
        end
        @(posedge mclk);
        line_energy <= 1'b0;
        settle(3);
        `CHK(ctl, exp_ctl(PMC_SAVING, 1'b1, 1'b0, 1'b1))
        apb(1'b0, IDX_PWR_STAT, 32'h0);
        `CHK(q, 32'h1E)
        cable_present <= 1'b1;
        settle(3);
        `CHK(phy_rx_en, 2'b11)
        cable_present <= 1'b0;
        an_enable     <= 1'b0;
        settle(3);
        `CHK(phy_rx_en, 2'b11)
        an_enable <= 1'b1;
        apb(1'b1, IDX_GLB_PWR, 32'h2);
        apb(1'b1, IDX_PORT2_CTL, 32'h8);
        settle(3);
        `CHK(phy_pdn, 2'b10)
        apb(1'b0, IDX_GO_SLEEP, 32'h0);
        `CHK(q, 32'h3)
        apb(1'b1, IDX_PORT2_CTL, 32'h0);
        apb(1'b1, IDX_GLB_PWR, 32'h0);
        settle(3);
        `CHK(ctl, 8'hFE)
        apb(1'b1, IDX_GLB_PWR, 32'h1);
        settle(10);
        `CHK(energy_det_en, 1'b0)
        line_energy <= 1'b1;
        @(posedge mclk);
        line_energy <= 1'b0;
        settle(10);
        `CHK(energy_det_en, 1'b0)
        wait_edet(1'b1, 40);
        settle(2);
        `CHK(ctl, exp_ctl(PMC_ENERGY, 1'b0, 1'b1, 1'b0))
        apb(1'b0, IDX_PWR_STAT, 32'h0);
        `CHK(q, 32'h01)
        pulse_check();
        line_energy <= 1'b1;
        wait_edet(1'b0, 5);
        settle(2);
        `CHK(ctl, exp_ctl(PMC_ENERGY, 1'b0, 1'b0, 1'b0))
        give_verdict();
    end

endmodule : pmc_power_ctrl_test
